// file: hw/tcr_timer_ctrl.sv
// Timer control: run gating, split mode, timebase choice, capture into reload registers
`timescale 1ns/1ps
module tcr_timer_ctrl
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_write,
    output logic [7:0] sfr_rdata,
    input wire logic usb_sof_event,
    input wire logic lfo_clk_in,
    input wire logic ext_osc_in,
    input wire logic timer_int_enable,
    output logic timer_int_req
);
    // Software-visible register state
    logic [7:0] timer_control;
    logic [7:0] reload_low_byte;
    logic [7:0] reload_high_byte;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;

    // Timebase and synchroniser stages
    logic tick;
    logic sof_meta;
    logic sof_sync;
    logic sof_prev;
    logic lfo_meta;
    logic lfo_sync;
    logic lfo_prev;

    // Decoded control fields
    logic capture_event;
    logic capture_enable;
    logic split_mode_select;
    logic run_control;
    logic capture_source_select;
    logic external_clock_select;

    // Count enables, wraps and flag sources
    logic low_run;
    logic high_run;
    logic low_wrap;
    logic high_wrap;
    logic full_wrap;
    logic ovf_high_set;

    // Write strobe aimed at one register; shared by the control and count registers
    function automatic logic write_hit
    (
        input logic wr,
        input logic [7:0] addr,
        input logic [7:0] target
    );
        write_hit = wr && (addr == target);
    endfunction

    assign capture_enable = timer_control[tcr_pkg::BIT_CAPTURE_ENABLE];
    assign split_mode_select = timer_control[tcr_pkg::BIT_SPLIT_MODE];
    assign run_control = timer_control[tcr_pkg::BIT_RUN_CONTROL];
    assign capture_source_select = timer_control[tcr_pkg::BIT_CAPTURE_SOURCE];
    assign external_clock_select = timer_control[tcr_pkg::BIT_EXT_CLOCK];

    tcr_tick_gen u_tick
    (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .external_clock_select(external_clock_select),
        .ext_osc_in(ext_osc_in),
        .tick(tick)
    );

    // Frame event synchroniser; edges taken after the second stage only
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sof_meta <= 1'b0;
            sof_sync <= 1'b0;
            sof_prev <= 1'b0;
        end
        else
        begin
            sof_meta <= usb_sof_event;
            sof_sync <= sof_meta;
            sof_prev <= sof_sync;
        end
    end

    // Oscillator synchroniser; levels shorter than one clock may be missed
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lfo_meta <= 1'b0;
            lfo_sync <= 1'b0;
            lfo_prev <= 1'b0;
        end
        else
        begin
            lfo_meta <= lfo_clk_in;
            lfo_sync <= lfo_meta;
            lfo_prev <= lfo_sync;
        end
    end

    // Rising edge of the chosen source, only while capture is on
    assign capture_event = capture_enable && (capture_source_select ?
        (lfo_sync && !lfo_prev) : (sof_sync && !sof_prev));

    // Run gating: split mode lets the low byte free-run
    assign low_run = tick && (split_mode_select || run_control);
    assign high_run = tick && run_control;
    assign low_wrap = low_run && (count_low_byte == 8'hFF);
    assign high_wrap = high_run && (count_high_byte == 8'hFF);
    assign full_wrap = low_wrap && (count_high_byte == 8'hFF);

    // High flag source: high byte alone in split mode, full 16-bit wrap otherwise
    assign ovf_high_set = split_mode_select ? high_wrap : full_wrap;

    // Control register; overflow flags set by hardware win over a software clear
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            timer_control <= tcr_pkg::CONTROL_RESET;
        else
        begin
            if (write_hit(sfr_write, sfr_addr, tcr_pkg::ADDR_CONTROL))
                timer_control <= sfr_wdata;
            if (low_wrap)
                timer_control[tcr_pkg::BIT_OVF_LOW] <= 1'b1;
            if (ovf_high_set)
                timer_control[tcr_pkg::BIT_OVF_HIGH] <= 1'b1;
        end
    end

    // Reload registers: capture beats a software write in the same cycle
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reload_low_byte <= tcr_pkg::RELOAD_RESET;
            reload_high_byte <= tcr_pkg::RELOAD_RESET;
        end
        else if (capture_event)
        begin
            reload_low_byte <= count_low_byte;
            reload_high_byte <= count_high_byte;
        end
        else if (sfr_write)
        begin
            if (sfr_addr == tcr_pkg::ADDR_RELOAD_LOW)
                reload_low_byte <= sfr_wdata;
            if (sfr_addr == tcr_pkg::ADDR_RELOAD_HIGH)
                reload_high_byte <= sfr_wdata;
        end
    end

    // Low byte counter; auto-reload only outside capture mode
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            count_low_byte <= tcr_pkg::COUNT_RESET;
        else if (write_hit(sfr_write, sfr_addr, tcr_pkg::ADDR_COUNT_LOW))
            count_low_byte <= sfr_wdata;
        else if (low_wrap && !capture_enable)
            count_low_byte <= reload_low_byte;
        else if (low_run)
            count_low_byte <= count_low_byte + 8'h01;
    end

    // High byte counter; in 16-bit mode it steps on the low byte carry
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            count_high_byte <= tcr_pkg::COUNT_RESET;
        else if (write_hit(sfr_write, sfr_addr, tcr_pkg::ADDR_COUNT_HIGH))
            count_high_byte <= sfr_wdata;
        else if (split_mode_select)
        begin
            if (high_wrap && !capture_enable)
                count_high_byte <= reload_high_byte;
            else if (high_run)
                count_high_byte <= count_high_byte + 8'h01;
        end
        else if (full_wrap && !capture_enable)
            count_high_byte <= reload_high_byte;
        else if (low_wrap)
            count_high_byte <= count_high_byte + 8'h01;
    end

    // Interrupt request pulse on each capture when enabled
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            timer_int_req <= 1'b0;
        else
            timer_int_req <= capture_event && timer_int_enable;
    end

    // Registered read port; unmapped addresses read zero
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            sfr_rdata <= 8'h00;
        else
        begin
            case (sfr_addr)
                tcr_pkg::ADDR_CONTROL: sfr_rdata <= timer_control;
                tcr_pkg::ADDR_RELOAD_LOW: sfr_rdata <= reload_low_byte;
                tcr_pkg::ADDR_RELOAD_HIGH: sfr_rdata <= reload_high_byte;
                tcr_pkg::ADDR_COUNT_LOW: sfr_rdata <= count_low_byte;
                tcr_pkg::ADDR_COUNT_HIGH: sfr_rdata <= count_high_byte;
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end
endmodule

// file: hw/tcr_pkg.sv
// Package: register map, field positions, reset values and timing counts for the timer block
package tcr_pkg;
    // Special function register addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h91;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;
    // Control register field positions
    localparam int BIT_OVF_HIGH = 7;
    localparam int BIT_OVF_LOW = 6;
    localparam int BIT_LOW_INT_EN = 5;
    localparam int BIT_CAPTURE_ENABLE = 4;
    localparam int BIT_SPLIT_MODE = 3;
    localparam int BIT_RUN_CONTROL = 2;
    localparam int BIT_CAPTURE_SOURCE = 1;
    localparam int BIT_EXT_CLOCK = 0;
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    // Timebase dividers
    localparam logic [3:0] SYS_DIV = 4'hC;
    localparam logic [3:0] EXT_DIV = 4'h8;
endpackage

// file: hw/tcr_tick_gen.sv
// Timebase tick generator: system clock divided by 12 or synchronised external clock divided by 8
`timescale 1ns/1ps
module tcr_tick_gen
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic external_clock_select,
    input wire logic ext_osc_in,
    output logic tick
);
    logic [3:0] sys_cnt;
    logic [3:0] ext_cnt;
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic sys_tick;
    logic ext_tick;

    // Divide system clock by 12
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            sys_cnt <= 4'h0;
        else if (sys_cnt == tcr_pkg::SYS_DIV - 4'h1)
            sys_cnt <= 4'h0;
        else
            sys_cnt <= sys_cnt + 4'h1;
    end
    assign sys_tick = (sys_cnt == tcr_pkg::SYS_DIV - 4'h1);

    // Two-stage synchroniser; external source must be slower than half the system clock
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end
        else
        begin
            ext_meta <= ext_osc_in;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // Count rising edges of the synchronised oscillator, every eighth gives a tick
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            ext_cnt <= 4'h0;
        else if (ext_sync && !ext_prev)
            ext_cnt <= (ext_cnt == tcr_pkg::EXT_DIV - 4'h1) ? 4'h0 : ext_cnt + 4'h1;
    end
    assign ext_tick = ext_sync && !ext_prev && (ext_cnt == tcr_pkg::EXT_DIV - 4'h1);

    assign tick = external_clock_select ? ext_tick : sys_tick;
endmodule

// file: test/tcr_timer_ctrl_monitor.sv
// Port-level assertions for the timer control block
`timescale 1ns/1ps
module tcr_timer_ctrl_monitor
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_write,
    input wire logic [7:0] sfr_rdata,
    input wire logic usb_sof_event,
    input wire logic lfo_clk_in,
    input wire logic ext_osc_in,
    input wire logic timer_int_enable,
    input wire logic timer_int_req
);
    logic [7:0] ctl;
    // Shadow of the control byte; flag bits set by hardware are masked
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            ctl <= tcr_pkg::CONTROL_RESET;
        else if (sfr_write && sfr_addr == tcr_pkg::ADDR_CONTROL)
            ctl <= sfr_wdata;
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_armed;
        ctl[4] && timer_int_enable;
    endsequence
    sequence s_sof_rise;
        !usb_sof_event ##1 usb_sof_event && !ctl[1];
    endsequence
    sequence s_lfo_rise;
        !lfo_clk_in ##1 lfo_clk_in && ctl[1];
    endsequence
    // Stopped timer: two quiet cycles on the high byte
    sequence s_high_idle;
        (sfr_addr == tcr_pkg::ADDR_COUNT_HIGH && !sfr_write && !ctl[2]) [*2];
    endsequence
    a_sof_capture: assert property (s_sof_rise ##0 s_armed |-> ##3 timer_int_req)
        else $error("frame event gave no capture pulse");
    a_lfo_capture: assert property (s_lfo_rise ##0 s_armed |-> ##3 timer_int_req)
        else $error("oscillator event gave no capture pulse");
    a_int_single: assert property (timer_int_req |=> !timer_int_req)
        else $error("interrupt pulse too long");
    a_int_enabled: assert property (timer_int_req |-> $past(timer_int_enable) && ctl[4])
        else $error("interrupt without enable");
    a_ctl_readback: assert property (sfr_addr == tcr_pkg::ADDR_CONTROL
        |=> ((sfr_rdata ^ $past(ctl)) & 8'h3F) == 8'h00) else $error("control readback");
    a_unmapped_zero: assert property (sfr_addr < 8'h91 || sfr_addr > 8'h95 |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_stop_holds: assert property (s_high_idle |=> $stable(sfr_rdata))
        else $error("stopped high byte moved");
    a_split_low_runs: assert property (ctl[3] && !ctl[0] && !sfr_write
        && sfr_addr == tcr_pkg::ADDR_COUNT_LOW |-> ##[2:30] $changed(sfr_rdata))
        else $error("split low byte idle");
endmodule

bind tcr_timer_ctrl tcr_timer_ctrl_monitor u_mon (.core_clk, .sys_rst, .sfr_addr, .sfr_wdata,
    .sfr_write, .sfr_rdata, .usb_sof_event, .lfo_clk_in, .ext_osc_in, .timer_int_enable,
    .timer_int_req);

// file: test/testbench.sv
// Self-checking bench for the timer control block
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0, sys_rst = 1'b1, sfr_write = 1'b0, timer_int_req, seen;
    logic usb_sof_event = 1'b0, lfo_clk_in = 1'b0, ext_osc_in = 1'b0, timer_int_enable = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, v0, v1;
    int err_total = 0;
    int comparisons = 0;
    tcr_timer_ctrl u_dut (.core_clk, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_write, .sfr_rdata,
        .usb_sof_event, .lfo_clk_in, .ext_osc_in, .timer_int_enable, .timer_int_req);
    // Free-running 100 MHz clock
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Extra idle edge keeps two writes from touching the strobe in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_write <= 1'b1;
        @(posedge core_clk);
        sfr_write <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_addr <= a;
        repeat (2) @(posedge core_clk);
        d = sfr_rdata;
    endtask
    // Count step over n+2 cycles; t toggles of the external oscillator first
    task automatic rate(input logic [7:0] c, a, input int n, t, input logic [7:0] dv);
        wr(tcr_pkg::ADDR_CONTROL, c);
        rd(a, v0);
        for (int i = 0; i < n; i++)
        begin
            if (i < t)
                ext_osc_in <= ~ext_osc_in;
            @(posedge core_clk);
        end
        rd(a, v1);
        check("count step", v1 - v0, dv);
    endtask
    // Frozen count, one event, then reload pair and interrupt pulse
    task automatic cap(input logic [7:0] c, input bit lfo, en, input logic [15:0] cnt, exp);
        wr(tcr_pkg::ADDR_CONTROL, c);
        wr(tcr_pkg::ADDR_COUNT_LOW, cnt[7:0]);
        wr(tcr_pkg::ADDR_COUNT_HIGH, cnt[15:8]);
        timer_int_enable <= en;
        seen = 1'b0;
        lfo_clk_in <= lfo;
        usb_sof_event <= !lfo;
        repeat (8)
        begin
            @(posedge core_clk);
            seen = seen | timer_int_req;
        end
        lfo_clk_in <= 1'b0;
        usb_sof_event <= 1'b0;
        rd(tcr_pkg::ADDR_RELOAD_LOW, v0);
        rd(tcr_pkg::ADDR_RELOAD_HIGH, v1);
        check("reload pair", v0, exp[7:0]);
        check("reload pair", v1, exp[15:8]);
        check("interrupt", {7'h00, seen}, {7'h00, en && c[4] && exp == cnt});
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        for (int a = 8'h90; a < 8'h97; a++)
        begin
            rd(8'(a), v0);
            check("reset value", v0, tcr_pkg::CONTROL_RESET);
        end
        rate(8'h04, tcr_pkg::ADDR_COUNT_LOW, 118, 0, 8'h0A);
        rate(8'h00, tcr_pkg::ADDR_COUNT_LOW, 40, 0, 8'h00);
        rate(8'h08, tcr_pkg::ADDR_COUNT_LOW, 118, 0, 8'h0A);
        rate(8'h08, tcr_pkg::ADDR_COUNT_HIGH, 40, 0, 8'h00);
        rate(8'h05, tcr_pkg::ADDR_COUNT_LOW, 40, 0, 8'h00);
        rate(8'h05, tcr_pkg::ADDR_COUNT_LOW, 170, 160, 8'h0A);
        cap(8'h10, 0, 1, 16'hA53C, 16'hA53C);
        cap(8'h12, 1, 1, 16'hC35A, 16'hC35A);
        cap(8'h12, 0, 1, 16'h1234, 16'hC35A);
        cap(8'h10, 0, 0, 16'h0F0E, 16'h0F0E);
        cap(8'h00, 0, 1, 16'h7788, 16'h0F0E);
        complete_run();
    end
endmodule
